/* design/ovd_pkg.sv */
// Purpose: constants for the video RAM entry decoder
// Assumes: entries arrive as even/odd nibble pairs
// Notes:   character ROM addresses are 12 bits wide
`default_nettype none
package ovd_pkg;
    localparam int          ENTRY_W       = 8;
    localparam int          TYPE_MSB      = 7;
    localparam int          TYPE_LSB      = 6;
    localparam int          DATA_W        = 6;
    localparam int          ROM_ADDR_W    = 12;
    localparam int          VRAM_ADDR_W   = 7;
    localparam logic [1:0]  TYPE_PATTERN  = 2'h0;
    localparam logic [1:0]  TYPE_CR_BANK1 = 2'h1;
    localparam logic [1:0]  TYPE_CONTROL  = 2'h2;
    localparam logic [1:0]  TYPE_CR_BANK2 = 2'h3;
    localparam logic [1:0]  ROM_BANK0_TOP = 2'h2;
    localparam logic [1:0]  ROM_BANK1_TOP = 2'h3;
    localparam logic [11:0] ROM_REGION_LO = 12'h800;
    localparam logic [11:0] ROM_REGION_HI = 12'hF7F;
    localparam logic [3:0]  PAT_STEP_LAST = 4'hE;
    localparam logic [3:0]  CTRL_NIBBLE   = 4'hF;
    localparam logic        BANK_RST      = 1'b0;
    typedef enum logic [1:0] {
        OVD_IDLE,
        OVD_PATTERN
    } ovd_state_e;
endpackage : ovd_pkg
`default_nettype wire

/* design/ovd_entry_decoder.sv */
// Purpose: classify video RAM entries and form character ROM and
//          return addresses for the on-screen display stream
// Assumes: one entry per entry_valid_i pulse, ROM steps paced by
//          step_ready_i from the fetch path
// Notes:   all outputs are registered
// Operation
// (R1) entry is 8 bits from even/odd nibbles; top 2 type, low 6 data
// (R2) type 00 selects a character pattern, type 10 selects control data
// (R3) type 01 is carriage return into the first VRAM bank
// (R4) type 11 is carriage return into the second VRAM bank
// (R5) pattern selector goes to ROM address bits 9 to 4
// (R6) bank flag picks 080xH base or 0C0xH base
// (R7) pattern fetches stay inside 0800H to 0F7FH
// (R8) one pattern is 15 steps, low nibble 0 to E
// (R9) control selector maps to bits 9 to 4 with low nibble F
// (R10) a carriage return ends the current row
// (R11) two carriage returns in a row end the screen
// (R12) return payload addresses the first entry of next row
// (R13) payload upper 3 bits are row, lower 3 are column high bits
// (R14) return column address bit 0 is forced to zero
// (R15) return target is row times sixteen plus column in chosen bank
// (R16) software avoids second-bank selectors beyond the ROM region top
`default_nettype none
module ovd_entry_decoder (
    input  wire logic                          clk_i,
    input  wire logic                          sys_rst_i,
    input  wire logic                          clk_en_i,
    input  wire logic                          entry_valid_i,
    input  wire logic [3:0]                    entry_even_i,
    input  wire logic [3:0]                    entry_odd_i,
    input  wire logic                          char_rom_bank_select_i,
    input  wire logic                          step_ready_i,
    output logic                               busy_o,
    output logic                               rom_valid_o,
    output logic [ovd_pkg::ROM_ADDR_W-1:0]     rom_addr_o,
    output logic                               rom_is_control_o,
    output logic                               rom_range_err_o,
    output logic                               cr_valid_o,
    output logic                               cr_bank2_o,
    output logic [ovd_pkg::VRAM_ADDR_W-1:0]    cr_addr_o,
    output logic                               row_end_o,
    output logic                               screen_end_o
);

////////////////////////////////////////////////////////////////////////
    logic [ovd_pkg::ENTRY_W-1:0]  entry;
    logic [1:0]                   entry_type;
    logic [ovd_pkg::DATA_W-1:0]   entry_data;
    logic                         is_cr;
    logic                         take;
    logic [ovd_pkg::ROM_ADDR_W-1:0] sel_base;
    logic                         prev_cr_reg;
    logic [3:0]                   step_reg;
    ovd_pkg::ovd_state_e          state_reg;
    logic                         pat_in_region;
    logic [4:0]                   seen_steps_reg;

    // every check below runs on the one system clock
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);

    assign entry      = {entry_even_i, entry_odd_i}; // R1
    assign entry_type = entry[ovd_pkg::TYPE_MSB:ovd_pkg::TYPE_LSB]; // R1
    assign entry_data = entry[ovd_pkg::DATA_W-1:0]; // R1
    assign is_cr      = entry_type[0]; // R3 R4
    // new entries are only taken while no pattern burst is running
    assign take       = clk_en_i && entry_valid_i &&
                        state_reg == ovd_pkg::OVD_IDLE;
    // selector into bits 9..4, bank flag into bit 10, region bit 11
    assign sel_base   = {1'b1, char_rom_bank_select_i, entry_data,
                         4'h0}; // R5 R6
    // bank 1 tops out below its last selectors; those are never fetched as patterns
    assign pat_in_region = sel_base <= ovd_pkg::ROM_REGION_HI; // R7

////////////////////////////////////////////////////////////////////////
    // pattern burst sequencer
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_reg <= ovd_pkg::OVD_IDLE;
            step_reg  <= 4'h0;
        end else if (clk_en_i) begin
            unique case (state_reg)
                ovd_pkg::OVD_IDLE: begin
                    // out-of-region selectors start no burst: no steps come
                    if (take && entry_type == ovd_pkg::TYPE_PATTERN
                        && pat_in_region) begin
                        state_reg <= ovd_pkg::OVD_PATTERN; // R2
                        step_reg  <= 4'h0;
                    end
                end
                ovd_pkg::OVD_PATTERN: begin
                    if (step_ready_i) begin
                        if (step_reg == ovd_pkg::PAT_STEP_LAST) begin
                            state_reg <= ovd_pkg::OVD_IDLE; // R8
                        end else begin
                            step_reg <= step_reg + 4'h1; // R8
                        end
                    end
                end
                default: state_reg <= ovd_pkg::OVD_IDLE;
            endcase
        end
    end

////////////////////////////////////////////////////////////////////////
    // ROM address stream; stays on each step until the path accepts it
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rom_valid_o      <= 1'b0;
            rom_addr_o       <= ovd_pkg::ROM_REGION_LO;
            rom_is_control_o <= 1'b0;
            rom_range_err_o  <= 1'b0;
            busy_o           <= 1'b0;
        end else if (clk_en_i) begin
            if (take && entry_type == ovd_pkg::TYPE_PATTERN) begin
                rom_valid_o      <= pat_in_region; // R7 R16
                rom_addr_o       <= sel_base; // R5 R6
                rom_is_control_o <= 1'b0;
                busy_o           <= pat_in_region; // R8
                // out-of-region selectors are flagged, never fetched
                rom_range_err_o  <= !pat_in_region; // R7
            end else if (take && entry_type == ovd_pkg::TYPE_CONTROL) begin
                rom_valid_o      <= 1'b1;
                rom_addr_o       <= {sel_base[11:4],
                                     ovd_pkg::CTRL_NIBBLE}; // R9
                rom_is_control_o <= 1'b1; // R2
                rom_range_err_o  <= 1'b0;
            end else if (state_reg == ovd_pkg::OVD_PATTERN
                         && step_ready_i) begin
                if (step_reg == ovd_pkg::PAT_STEP_LAST) begin
                    rom_valid_o <= 1'b0;
                    busy_o      <= 1'b0;
                end else begin
                    rom_addr_o <= {rom_addr_o[11:4],
                                   step_reg + 4'h1}; // R8
                end
            end else if (state_reg == ovd_pkg::OVD_IDLE) begin
                rom_valid_o     <= 1'b0;
                rom_range_err_o <= 1'b0;
                busy_o          <= 1'b0;
            end
        end
    end

////////////////////////////////////////////////////////////////////////
    // carriage return decode, one-cycle pulses per taken entry
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cr_valid_o   <= 1'b0;
            cr_bank2_o   <= 1'b0;
            cr_addr_o    <= '0;
            row_end_o    <= 1'b0;
            screen_end_o <= 1'b0;
            prev_cr_reg  <= 1'b0;
        end else if (clk_en_i) begin
            cr_valid_o   <= 1'b0;
            row_end_o    <= 1'b0;
            screen_end_o <= 1'b0;
            if (take) begin
                prev_cr_reg <= is_cr; // R11
                if (is_cr) begin
                    cr_valid_o <= 1'b1; // R12
                    cr_bank2_o <= entry_type == ovd_pkg::TYPE_CR_BANK2; // R3 R4
                    // row*16 + column, column bit 0 always zero
                    cr_addr_o  <= {entry_data[5:3], entry_data[2:0],
                                   1'b0}; // R13 R14 R15
                    row_end_o  <= 1'b1; // R10
                    screen_end_o <= prev_cr_reg; // R11
                end
            end
        end
    end

////////////////////////////////////////////////////////////////////////
    // steps counted apart from step_reg, so a broken step_reg shows
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            seen_steps_reg <= 5'h00;
        end else if (clk_en_i) begin
            if (take) begin
                seen_steps_reg <= 5'h00;
            end else if (rom_valid_o && !rom_is_control_o
                         && step_ready_i) begin
                seen_steps_reg <= seen_steps_reg + 5'h01;
            end
        end
    end

////////////////////////////////////////////////////////////////////////
    sequence cr_taken_s;
        take && is_cr;
    endsequence

    // two returns taken on back-to-back edges
    sequence cr_pair_s;
        cr_taken_s ##1 cr_taken_s;
    endsequence

    // any other entry taken breaks a return pair
    sequence other_taken_s;
        take && !is_cr;
    endsequence

    cr_row_end_a: assert property ( // R10
        cr_taken_s |=> row_end_o && cr_valid_o)
        else $error("carriage return did not end row");

    cr_quiet_a: assert property ( // R10
        other_taken_s |=> !row_end_o && !cr_valid_o)
        else $error("row ended without a return");

    cr_lsb_zero_a: assert property ( // R14
        cr_valid_o |-> cr_addr_o[0] == 1'b0)
        else $error("return column lsb not zero");

    cr_target_a: assert property ( // R13
        cr_taken_s |=> cr_addr_o == {$past(entry_data), 1'b0})
        else $error("return address wrong");

    // the target stays put for the row fetch that follows
    cr_hold_a: assert property ( // R12
        !(take && is_cr) |=> $stable(cr_addr_o) && $stable(cr_bank2_o))
        else $error("return target changed without a return");

    cr_bank_a: assert property ( // R4
        cr_taken_s |=> cr_bank2_o == $past(entry_type[1]))
        else $error("return bank wrong");

    cr_first_bank_a: assert property ( // R3
        take && entry_type == ovd_pkg::TYPE_CR_BANK1 |=> !cr_bank2_o)
        else $error("first-bank return marked second bank");

    screen_pair_a: assert property ( // R11
        screen_end_o |-> row_end_o)
        else $error("screen end without row end");

    screen_end_a: assert property ( // R11
        cr_pair_s |=> screen_end_o)
        else $error("two returns did not end screen");

    screen_break_a: assert property ( // R11
        other_taken_s ##1 cr_taken_s |=> !screen_end_o)
        else $error("single return ended screen");

    pat_base_a: assert property ( // R5 R6
        take && entry_type == ovd_pkg::TYPE_PATTERN
        |=> rom_addr_o == {1'b1, $past(char_rom_bank_select_i),
                           $past(entry_data), 4'h0})
        else $error("pattern base wrong");

    ctrl_nibble_a: assert property ( // R9
        rom_is_control_o && rom_valid_o |-> rom_addr_o[3:0] == 4'hF)
        else $error("control nibble not F");

    ctrl_addr_a: assert property ( // R9
        take && entry_type == ovd_pkg::TYPE_CONTROL
        |=> rom_valid_o && rom_addr_o[9:4] == $past(entry_data)
        && rom_addr_o[10] == $past(char_rom_bank_select_i))
        else $error("control address wrong");

    rom_region_a: assert property ( // R7
        rom_valid_o |-> rom_addr_o >= ovd_pkg::ROM_REGION_LO
        && rom_addr_o <= ovd_pkg::ROM_REGION_HI)
        else $error("fetch outside character rom");

    range_err_a: assert property ( // R7
        rom_range_err_o |-> !rom_valid_o && !busy_o)
        else $error("out-of-region selector fetched");

    pat_steps_a: assert property ( // R8
        rom_valid_o && !rom_is_control_o && step_ready_i && clk_en_i
        && rom_addr_o[3:0] != 4'hE
        |=> rom_addr_o[3:0] == $past(rom_addr_o[3:0]) + 4'h1)
        else $error("pattern step skipped");

    // a step held under stall must not move
    pat_stall_a: assert property ( // R8
        busy_o && !step_ready_i |=> $stable(rom_addr_o) && rom_valid_o)
        else $error("pattern step moved without ready");

    pat_count_a: assert property ( // R8
        $fell(busy_o)
        |-> seen_steps_reg == {1'b0, ovd_pkg::PAT_STEP_LAST} + 5'h01)
        else $error("pattern burst not 15 steps");

    busy_fetch_a: assert property ( // R8
        busy_o |-> rom_valid_o && !rom_is_control_o)
        else $error("burst without pattern fetch");

    burst_ignore_a: assert property ( // R8
        busy_o && entry_valid_i && clk_en_i |=> !cr_valid_o)
        else $error("entry taken during burst");

    type_class_a: assert property ( // R2
        take && entry_type == ovd_pkg::TYPE_CONTROL
        |=> rom_is_control_o && !cr_valid_o && !busy_o)
        else $error("control entry misclassified");

    // clock enable low must freeze busy_o, rom_addr_o, cr_addr_o and cr_valid_o
    freeze_a: assert property (
        !clk_en_i |=> $stable(busy_o) && $stable(rom_addr_o)
        && $stable(cr_addr_o) && $stable(cr_valid_o))
        else $error("state moved with clock enable low");

endmodule : ovd_entry_decoder
`default_nettype wire

/* tb/ovd_fetch_model.sv */
// Purpose: fetch path stand-in that takes character ROM steps
// Assumes: driven on the falling edge of the clock
// Notes:   slow mode takes a step only every other cycle
`default_nettype none
module ovd_fetch_model (
    input  wire logic clk_i,
    input  wire logic sys_rst_i,
    input  wire logic rom_valid_i,
    input  wire logic slow_i,
    output var  logic step_ready_o
);
    timeunit 1ns;
    timeprecision 1ns;
    always @(negedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            step_ready_o <= 1'h0;
        end else begin
            // stalls force the decoder to hold its step address
            step_ready_o <= rom_valid_i & ~(slow_i & step_ready_o);
        end
    end
endmodule : ovd_fetch_model
`default_nettype wire

/* tb/ovd_entry_decoder_tb.sv */
// Purpose: self-checking bench for the entry decoder
// Assumes: inputs change on the falling edge
// Notes:   out-of-range burst is run last, it has no steps to take
`default_nettype none
module ovd_entry_decoder_tb;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [7:0]  e;
        logic        b;
        logic [11:0] a;
        logic        c;
        logic        r;
        logic [6:0]  ca;
        logic        b2;
        logic        se;
    } ovd_row_s;
    ovd_row_s   rows [8];
    logic       clk, rst, en, valid, bank, ready, slow;
    logic [3:0] even, odd;
    logic       busy, rv, ctl, rerr, crv, crb2, rend, send;
    logic [11:0] addr;
    logic [6:0] cra;
    int         fail_count = 0;
    int         cmp_count = 0;
    int         cycles = 0;
    int         n;
    ////////////////////////////////////////////////////////////////////
    ovd_entry_decoder dut (.clk_i(clk), .sys_rst_i(rst), .clk_en_i(en),
        .entry_valid_i(valid), .entry_even_i(even), .entry_odd_i(odd),
        .char_rom_bank_select_i(bank), .step_ready_i(ready),
        .busy_o(busy), .rom_valid_o(rv), .rom_addr_o(addr),
        .rom_is_control_o(ctl), .rom_range_err_o(rerr),
        .cr_valid_o(crv), .cr_bank2_o(crb2), .cr_addr_o(cra),
        .row_end_o(rend), .screen_end_o(send));
    ovd_fetch_model partner (.clk_i(clk), .sys_rst_i(rst),
        .rom_valid_i(rv), .slow_i(slow), .step_ready_o(ready));
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [11:0] s,
                       input logic [11:0] x);
        cmp_count++;
        if (s !== x) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, x, s);
        end
    endtask : chk
    task automatic put_e(input logic [7:0] e, input logic bk);
        @(negedge clk);
        {even, odd} = e;
        bank = bk;
        valid = 1'h1;
        @(negedge clk);
        valid = 1'h0;
        #1;
    endtask : put_e
    task automatic final_report;
        if (fail_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : final_report
    ////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles > 3000) begin
            fail_count++;
            final_report();
        end
    end
    initial begin
        {rst, en, valid, even, odd, bank, slow} = 13'h1800;
        rows = '{'{8'h05, 1'h0, 12'h850, 1'h0, 1'h0, 7'h00, 1'h0, 1'h0},
                 '{8'h3F, 1'h0, 12'hBF0, 1'h0, 1'h0, 7'h00, 1'h0, 1'h0},
                 '{8'h00, 1'h1, 12'hC00, 1'h0, 1'h0, 7'h00, 1'h0, 1'h0},
                 '{8'h37, 1'h1, 12'hF70, 1'h0, 1'h0, 7'h00, 1'h0, 1'h0},
                 '{8'h85, 1'h1, 12'hC5F, 1'h1, 1'h0, 7'h00, 1'h0, 1'h0},
                 '{8'hA0, 1'h0, 12'hA0F, 1'h1, 1'h0, 7'h00, 1'h0, 1'h0},
                 '{8'h53, 1'h0, 12'h000, 1'h0, 1'h1, 7'h26, 1'h0, 1'h0},
                 '{8'hFF, 1'h0, 12'h000, 1'h0, 1'h1, 7'h7E, 1'h1, 1'h1}};
        repeat (6) @(negedge clk);
        chk("reset addr", addr, 12'h800);
        chk("reset busy", busy, 12'h000);
        rst = 1'h0;
        foreach (rows[i]) begin
            put_e(rows[i].e, rows[i].b);
            if (rows[i].r) begin
                chk("cr valid", crv, 12'h001);
                chk("row end", rend, 12'h001);
                chk("cr addr", cra, rows[i].ca);
                chk("cr bank", crb2, rows[i].b2);
                chk("screen end", send, rows[i].se);
            end else begin
                chk("rom valid", rv, 12'h001);
                chk("rom addr", addr, rows[i].a);
                chk("control", ctl, rows[i].c);
                chk("no cr", crv, 12'h000);
                chk("busy", busy, 12'(!rows[i].c));
            end
            for (int k = 0; k < 40 && busy !== 1'h0; k++) @(negedge clk);
        end
        // back-to-back takes: control, return, return
        @(negedge clk);
        {even, odd} = 8'h85;
        valid = 1'h1;
        @(negedge clk);
        {even, odd} = 8'h53;
        @(negedge clk);
        chk("b2b no end", send, 12'h000);
        {even, odd} = 8'hC1;
        @(negedge clk);
        valid = 1'h0;
        chk("b2b end", send, 12'h001);
        chk("b2b addr", cra, 12'h002);
        chk("b2b bank", crb2, 12'h001);
        // clock enable low freezes pulses and refuses entries
        en = 1'h0;
        @(negedge clk);
        chk("frozen pulse", crv, 12'h001);
        {even, odd} = 8'h7F;
        valid = 1'h1;
        @(negedge clk);
        chk("frozen end", send, 12'h001);
        en = 1'h1;
        valid = 1'h0;
        @(negedge clk);
        chk("frozen take", cra, 12'h002);
        chk("pulse gone", crv, 12'h000);
        // stalled burst with a return entry offered mid-way
        slow = 1'h1;
        put_e(8'h12, 1'h0);
        {even, odd} = 8'h41;
        n = 0;
        for (int i = 0; i < 100 && busy === 1'h1; i++) begin
            if (rv === 1'h1 && ready === 1'h1) begin
                chk("step addr", addr, 12'(12'h920 + n));
                n++;
            end
            chk("ignored cr", crv, 12'h000);
            valid = 1'(i == 4);
            @(negedge clk);
            #1;
        end
        chk("steps", 12'(n), 12'h00F);
        slow = 1'h0;
        put_e(8'h38, 1'h1);
        chk("range err", rerr, 12'h001);
        chk("range valid", rv, 12'h000);
        chk("range busy", busy, 12'h000);
        final_report();
    end
endmodule : ovd_entry_decoder_tb
`default_nettype wire
